// *** core/iiad_core.v ***
// Purpose: decode and execute for inherent, pointer and and/add instructions
// Assumes: one instruction offered per ready cycle; data memory inside
// Notes:   multi-cycle ops drop ready; other opcodes flagged as unhandled
`include "iiad_defines.vh"
module iiad_core #(
    parameter MEM_DEPTH = 256
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        instr_valid,
    input  wire [13:0] instr,
    input  wire        pc_change,
    output reg         instr_ready,
    output reg  [7:0]  acc,
    output reg  [15:0] pointer0,
    output reg  [15:0] pointer1,
    output reg         zero_bit,
    output reg         carry_bit,
    output reg         nibble_overflow_bit,
    output reg         expiry_bit,
    output reg         sleep_entry_bit,
    output reg         watchdog_clear_pulse,
    output reg         sleep_pulse,
    output reg         soft_reset_pulse,
    output reg         dir_load_pulse,
    output reg  [2:0]  dir_sel,
    output reg  [7:0]  dir_data,
    output reg         unhandled_pulse
);
    // =================================================================
    // state machine
    localparam ST_EXEC = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_STALL = 2'h2;
    reg  [1:0]  state;
    wire [15:0] mem_addr;
    wire        mem_we;
    wire [7:0]  mem_wdata;
    wire [7:0]  mem_rdata;
    reg  [2:0]  rd_kind;      // 0 acc load, 1 and-reg, 2 add-reg
    reg         rd_dest;
    reg  [6:0]  rd_faddr;
    reg         extra_pending;
    reg         pc_pending;   // a pc nop still owed after a busy op

    // =================================================================
    // helpers
    function [9:0] add8;      // {c, dc, sum}
        input [7:0] a;
        input [7:0] b;
        reg   [4:0] lo;
        reg   [8:0] full;
        begin
            lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            full = {1'b0, a} + {1'b0, b};
            add8 = {full[8], lo[4], full[7:0]};
        end
    endfunction

    function [15:0] add_signed6;
        input [15:0] p;
        input [5:0]  k;
        begin
            add_signed6 = p + {{10{k[5]}}, k};
        end
    endfunction

    iiad_dmem #(.AW(16), .DEPTH(MEM_DEPTH)) u_mem (
        .sys_clk (sys_clk),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata   (mem_rdata)
    );

    // =================================================================
    // decode
    wire        take    = instr_valid & instr_ready;
    wire        is_nop  = (instr == `IIAD_OP_NOP);
    wire        is_rst  = (instr == `IIAD_OP_SWRESET);
    wire        is_slp  = (instr == `IIAD_OP_SLEEP);
    wire        is_wdt  = (instr == `IIAD_OP_WDTCLR);
    wire        is_dir  = (instr[13:3] == `IIAD_DIRLOAD_HI) & ~is_slp & ~is_wdt;
    wire        is_pmod = (instr[13:4] == `IIAD_PTRMOD_HI);
    wire        is_padd = (instr[13:7] == `IIAD_GRP_PTRADD);
    wire        is_idx  = (instr[13:8] == `IIAD_GRP_IDXIND);
    wire        is_andl = (instr[13:8] == `IIAD_GRP_ANDLIT);
    wire        is_addl = (instr[13:8] == `IIAD_GRP_ADDLIT);
    wire        is_andr = (instr[13:8] == `IIAD_GRP_ANDREG);
    wire        is_addr = (instr[13:8] == `IIAD_GRP_ADDREG);
    wire        psel_m  = instr[`IIAD_MM_PTRSEL_BIT];
    wire        psel_k  = instr[`IIAD_PTRSEL_BIT];
    wire [1:0]  mm      = instr[1:0];
    wire [15:0] p_m     = psel_m ? pointer1 : pointer0;
    wire [15:0] p_k     = psel_k ? pointer1 : pointer0;
    wire [15:0] p_inc   = p_m + 16'h0001;
    wire [15:0] p_dec   = p_m - 16'h0001;
    wire        pre     = (mm == `IIAD_MM_PREINC) | (mm == `IIAD_MM_PREDEC);
    wire        inc     = (mm == `IIAD_MM_PREINC) | (mm == `IIAD_MM_POSTINC);
    wire [15:0] p_new   = inc ? p_inc : p_dec;
    wire [15:0] pm_addr = pre ? p_new : p_m;
    wire [15:0] pk_addr = add_signed6(p_k, instr[5:0]);
    wire [9:0]  sum_l   = add8(acc, instr[7:0]);
    wire [7:0   ] and_l = acc & instr[7:0];
    wire [6:0]  faddr   = instr[6:0];
    // register ops on a window register with pointer msb set
    wire        win_ext = (faddr == `IIAD_WIN0_ADDR & pointer0[15]) | (faddr == `IIAD_WIN1_ADDR & pointer1[15]);
    wire        ind_ext = is_pmod ? p_m[15] : p_k[15];
    wire [9:0]  sum_r   = add8(acc, mem_rdata);
    wire [7:0]  and_r   = acc & mem_rdata;
    reg  [7:0]  rd_res;
    always @* begin
        case (rd_kind)
            3'h1: rd_res = and_r;
            3'h2: rd_res = sum_r[7:0];
            default: rd_res = mem_rdata;
        endcase
    end

    // =================================================================
    // memory port
    // every exec-state access is presented at the taking edge, so the registered
    // read data stand one edge later, in the read state
    // the only access outside the exec state is a register write-back,
    // and no word is taken then, so the two never meet on the port
    // limitation: window addresses read plain memory, not through a pointer
    wire        is_ind    = is_pmod | is_idx;
    wire        is_reg    = is_andr | is_addr;
    wire        acc_wr    = is_pmod ? instr[`IIAD_WRITE_BIT] : instr[`IIAD_DEST_BIT];
    wire        in_exec   = (state == ST_EXEC);
    wire        back_wr   = (state == ST_READ) & (rd_kind != 3'h0) & rd_dest;
    wire [15:0] ind_addr  = is_pmod ? pm_addr : pk_addr;
    // ops that leave the exec state on their own owe the pc nop afterwards
    wire        goes_busy = (is_ind & (~acc_wr | ind_ext)) | is_reg;

    assign mem_we    = (in_exec & take & is_ind & acc_wr) | back_wr;
    assign mem_addr  = in_exec ? (is_ind ? ind_addr : {9'h000, faddr}) : {9'h000, rd_faddr};
    assign mem_wdata = in_exec ? acc : rd_res;


    // =================================================================
    // execute
    always @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_EXEC;
            instr_ready <= 1'b1;
            acc <= `IIAD_ACC_RESET;
            pointer0 <= `IIAD_PTR_RESET;
            pointer1 <= `IIAD_PTR_RESET;
            zero_bit <= 1'b0;
            carry_bit <= 1'b0;
            nibble_overflow_bit <= 1'b0;
            expiry_bit <= 1'b1;
            sleep_entry_bit <= 1'b1;
            watchdog_clear_pulse <= 1'b0;
            sleep_pulse <= 1'b0;
            soft_reset_pulse <= 1'b0;
            dir_load_pulse <= 1'b0;
            dir_sel <= 3'h0;
            dir_data <= 8'h00;
            unhandled_pulse <= 1'b0;
            pc_pending <= 1'b0;
            rd_kind <= 3'h0;
            rd_dest <= 1'b0;
            rd_faddr <= 7'h00;
            extra_pending <= 1'b0;
        end else begin
            watchdog_clear_pulse <= 1'b0;
            sleep_pulse <= 1'b0;
            soft_reset_pulse <= 1'b0;
            dir_load_pulse <= 1'b0;
            unhandled_pulse <= 1'b0;
            case (state)
                ST_EXEC: begin
                    if (take) begin
                        if (is_nop) begin
                            // nothing to do
                        end else if (is_rst) begin
                            soft_reset_pulse <= 1'b1;
                        end else if (is_wdt) begin
                            watchdog_clear_pulse <= 1'b1;
                            expiry_bit <= 1'b1;
                            sleep_entry_bit <= 1'b1;
                        end else if (is_slp) begin
                            sleep_pulse <= 1'b1;
                            expiry_bit <= 1'b1;
                            sleep_entry_bit <= 1'b0;
                        end else if (is_dir) begin
                            dir_load_pulse <= 1'b1;
                            dir_sel <= instr[2:0];
                            dir_data <= acc;
                        end else if (is_padd) begin
                            if (psel_k) begin
                                pointer1 <= pk_addr;
                            end else begin
                                pointer0 <= pk_addr;
                            end
                        end else if (is_pmod | is_idx) begin
                            if (is_pmod & psel_m) begin
                                pointer1 <= p_new;
                            end else if (is_pmod) begin
                                pointer0 <= p_new;
                            end
                            extra_pending <= ind_ext;
                            if (acc_wr) begin
                                // the write itself goes out on the memory port at this edge
                                if (ind_ext) begin
                                    state <= ST_STALL;
                                    instr_ready <= 1'b0;
                                end
                            end else begin
                                rd_kind <= 3'h0;
                                state <= ST_READ;
                                instr_ready <= 1'b0;
                            end
                        end else if (is_andl) begin
                            acc <= and_l;
                            zero_bit <= (and_l == 8'h00);
                        end else if (is_addl) begin
                            acc <= sum_l[7:0];
                            carry_bit <= sum_l[9];
                            nibble_overflow_bit <= sum_l[8];
                            zero_bit <= (sum_l[7:0] == 8'h00);
                        end else if (is_andr | is_addr) begin
                            rd_kind <= is_andr ? 3'h1 : 3'h2;
                            rd_dest <= instr[`IIAD_DEST_BIT];
                            rd_faddr <= faddr;
                            extra_pending <= win_ext;
                            state <= ST_READ;
                            instr_ready <= 1'b0;
                        end else begin
                            unhandled_pulse <= 1'b1;
                        end
                        if (pc_change) begin
                            // a busy op must not lose its read to the nop cycle
                            pc_pending <= goes_busy;
                            instr_ready <= 1'b0;
                            if (!goes_busy) begin
                                state <= ST_STALL;
                            end
                        end
                    end
                end
                ST_READ: begin
                    // memory read lands here; result written back this cycle
                    zero_bit <= (rd_res == 8'h00);
                    if (rd_kind == 3'h2) begin
                        carry_bit <= sum_r[9];
                        nibble_overflow_bit <= sum_r[8];
                    end
                    // a write-back to the register goes out on the memory port;
                    // otherwise the result lands in the accumulator
                    if (!back_wr) begin
                        acc <= rd_res;
                    end
                    if (extra_pending | pc_pending) begin
                        extra_pending <= 1'b0;
                        pc_pending <= extra_pending & pc_pending;
                        state <= ST_STALL;
                    end else begin
                        state <= ST_EXEC;
                        instr_ready <= 1'b1;
                    end
                end
                ST_STALL: begin
                    // idle cycle behaving as a nop
                    // a second one follows while a pc nop is still owed
                    extra_pending <= 1'b0;
                    pc_pending <= 1'b0;
                    if (!pc_pending) begin
                        state <= ST_EXEC;
                        instr_ready <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_EXEC;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end
endmodule // iiad_core

// *** core/iiad_defines.vh ***
// Purpose: shared constants for the inherent/indirect/arith decoder
// Assumes: 14-bit instruction words, 8-bit data
// Notes:   opcode patterns and field positions
`ifndef IIAD_DEFINES_VH
`define IIAD_DEFINES_VH
// =====================================================================
// inherent words and the pointer-modify pattern
`define IIAD_OP_NOP        14'h0000
`define IIAD_OP_SWRESET    14'h0001
`define IIAD_OP_SLEEP      14'h0063
`define IIAD_OP_WDTCLR     14'h0064
`define IIAD_DIRLOAD_HI    11'h00c
`define IIAD_PTRMOD_HI     10'h001
// =====================================================================
// literal and register groups, top six bits; top seven for the pointer add group
`define IIAD_GRP_PTRADD    7'h62
`define IIAD_GRP_IDXIND    6'h3f
`define IIAD_GRP_ANDLIT    6'h39
`define IIAD_GRP_ADDLIT    6'h3e
`define IIAD_GRP_ANDREG    6'h05
`define IIAD_GRP_ADDREG    6'h07
// =====================================================================
// field positions
`define IIAD_DEST_BIT      7
`define IIAD_PTRSEL_BIT    6
`define IIAD_WRITE_BIT     3
`define IIAD_MM_PTRSEL_BIT 2
// pointer update modes
`define IIAD_MM_PREINC     2'h0
`define IIAD_MM_PREDEC     2'h1
`define IIAD_MM_POSTINC    2'h2
`define IIAD_MM_POSTDEC    2'h3
// reset values
`define IIAD_PTR_RESET     16'h0000
`define IIAD_ACC_RESET     8'h00
// indirect window registers sit at data addresses 0 and 1
`define IIAD_WIN0_ADDR     7'h00
`define IIAD_WIN1_ADDR     7'h01
`endif

// *** core/iiad_dmem.v ***
// Purpose: small data memory with registered read
// Assumes: single clock, synchronous write
// Notes:   read data valid one cycle after address
module iiad_dmem #(
    parameter AW = 16,
    parameter DEPTH = 256
) (
    input  wire          sys_clk,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wdata,
    output reg  [7:0]    rdata
);
    reg [7:0] mem [0:DEPTH-1];
    always @(posedge sys_clk) begin
        if (we) begin
            mem[addr % DEPTH] <= wdata;
        end
        rdata <= mem[addr % DEPTH];
    end
endmodule // iiad_dmem

// *** testbench/iiad_core_properties.sv ***
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock, sync reset
// Notes:   take means valid and ready at an edge
module iiad_core_properties (
    input wire        sys_clk,
    input wire        rst,
    input wire        instr_valid,
    input wire [13:0] instr,
    input wire        pc_change,
    input wire        instr_ready,
    input wire [7:0]  acc,
    input wire [15:0] pointer0,
    input wire        carry_bit,
    input wire        expiry_bit,
    input wire        sleep_entry_bit,
    input wire        watchdog_clear_pulse,
    input wire        sleep_pulse,
    input wire        dir_load_pulse,
    input wire [2:0]  dir_sel,
    input wire [7:0]  dir_data
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire take = instr_valid && instr_ready;
    // =====================================================================
    // arithmetic
    chk_and_lit: assert property (take && instr[13:8] == 6'h39
        |=> acc == ($past(acc) & $past(instr[7:0]))) else $error("and literal wrong");
    chk_add_lit: assert property (take && instr[13:8] == 6'h3e
        |=> {carry_bit, acc} == {1'b0, $past(acc)} + {1'b0, $past(instr[7:0])}) else $error("add literal wrong");
    chk_ptr_add: assert property (take && instr[13:6] == 8'hc4
        |=> pointer0 == $past(pointer0) + {{10{$past(instr[5])}}, $past(instr[5:0])}) else $error("pointer add");
    // =====================================================================
    // inherent words
    chk_wdt_bits: assert property (take && instr == 14'h0064
        |=> watchdog_clear_pulse && expiry_bit && sleep_entry_bit) else $error("watchdog clear");
    chk_sleep_bits: assert property (take && instr == 14'h0063
        |=> sleep_pulse && expiry_bit && !sleep_entry_bit) else $error("standby entry");
    chk_dir_load: assert property (take && instr[13:3] == 11'h00c && instr[2:0] != 3'h3 && instr[2:0] != 3'h4
        |=> dir_load_pulse && dir_sel == $past(instr[2:0]) && dir_data == $past(acc)) else $error("dir load");
    // =====================================================================
    // stalls; a wrong stall count desynchronises the fetch side
    chk_pc_extra: assert property (take && pc_change
        |=> !instr_ready) else $error("no nop cycle");
    chk_reg_stall: assert property (take && (instr[13:8] == 6'h05 || instr[13:8] == 6'h07)
        |=> !instr_ready ##[1:3] instr_ready) else $error("register stall");
    chk_ind_stall: assert property (take && instr[13:4] == 10'h001 && !instr[3]
        |=> !instr_ready ##[1:3] instr_ready) else $error("indirect read stall");
endmodule // iiad_core_properties

// *** testbench/iiad_fetch_model.sv ***
// Purpose: fetch side offering words to the core
// Assumes: words change on falling edges only
// Notes:   a released bus shows the inverted word
module iiad_fetch_model (
    input  wire         sys_clk,
    input  wire         instr_ready,
    output logic        instr_valid,
    output logic [13:0] instr,
    output logic        pc_change
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        instr_valid = 1'b0;
        instr = 14'h3fff;
        pc_change = 1'b0;
    end
    // held until taken at a rising edge with ready high
    task automatic offer(input logic [13:0] w, input logic pc);
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr = w;
        pc_change = pc;
        while (instr_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    task automatic release_bus();
        @(negedge sys_clk);
        instr_valid = 1'b0;
        instr = ~instr;
        pc_change = 1'b0;
    endtask
endmodule // iiad_fetch_model

// *** testbench/iiad_core_bench.sv ***
// Purpose: self-checking bench for the decoder
// Assumes: one word in flight
// Notes:   unwritten memory is never read, its value is unknown
module iiad_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic rst;
    wire instr_valid, pc_change, instr_ready, zero_bit, carry_bit, nibble_overflow_bit, expiry_bit;
    wire sleep_entry_bit, watchdog_clear_pulse, sleep_pulse, soft_reset_pulse, dir_load_pulse, unhandled_pulse;
    wire [13:0] instr;
    wire [7:0] acc, dir_data;
    wire [15:0] pointer0, pointer1;
    wire [2:0] dir_sel;
    int n_mismatch, n_compared, seed, m_acc, m_z, m_c, m_dc, m_to, m_pd, e_stall, e_pulse;
    int m_p[2];
    int mem[256];
    logic [13:0] iw[10] = '{14'h0063, 14'h0064, 14'h0060, 14'h0061, 14'h0062, 14'h0065, 14'h0066, 14'h0067,
                            14'h0008, 14'h0000};
    iiad_core i_dut (.sys_clk, .rst, .instr_valid, .instr, .pc_change, .instr_ready, .acc, .pointer0, .pointer1,
        .zero_bit, .carry_bit, .nibble_overflow_bit, .expiry_bit, .sleep_entry_bit, .watchdog_clear_pulse,
        .sleep_pulse, .soft_reset_pulse, .dir_load_pulse, .dir_sel, .dir_data, .unhandled_pulse);
    iiad_fetch_model i_fetch (.sys_clk, .instr_ready, .instr_valid, .instr, .pc_change);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input int exp);
        n_compared++;
        if (got !== exp[15:0]) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp[15:0]);
        end
    endtask
    // =====================================================================
    // reference model
    task automatic arith(input int v, input int is_add, output int res);
        res = is_add ? m_acc + v : m_acc & v;
        if (is_add) begin
            m_c = res >> 8;
            m_dc = ((m_acc & 15) + (v & 15)) >> 4;
        end
        res &= 255;
        m_z = res == 0;
    endtask
    task automatic run(input logic [13:0] w, input logic pc);
        int lows;
        lows = 0;
        i_fetch.offer(w, pc);
        i_fetch.release_bus();
        cmp({watchdog_clear_pulse, sleep_pulse, dir_load_pulse, unhandled_pulse, soft_reset_pulse}, e_pulse);
        while (instr_ready !== 1'b1 && lows < 8) begin
            lows++;
            @(negedge sys_clk);
        end
        cmp(lows, e_stall + pc);
        cmp(acc, m_acc);
        cmp(pointer0, m_p[0]);
        cmp(pointer1, m_p[1]);
        cmp({zero_bit, carry_bit, nibble_overflow_bit}, m_z * 4 + m_c * 2 + m_dc);
        cmp({expiry_bit, sleep_entry_bit}, m_to * 2 + m_pd);
    endtask
    // ops whose stall reading is unclear are swapped for an add literal
    task automatic step(input int kind);
        int r, n, k, v, f, a, b, x, res;
        logic [13:0] w;
        r = $random(seed);
        n = r[6];
        k = r[5:0] - (r[5] ? 64 : 0);
        v = r[7:0];
        f = r[14:8];
        a = m_p[n];
        b = (r[0] ? a - 1 : a + 1) & 65535;
        x = (kind < 5 ? (r[1] ? a : b) : a + k) & 255;
        e_pulse = 0;
        e_stall = 0;
        if ((kind > 2 && kind < 7 && (x < 2 || (kind < 5 && a[15] != b[15]) || (kind % 2 == 0 && mem[x] < 0)))
            || (kind > 6 && (f < 2 || mem[f] < 0))) begin
            step(2);
            return;
        end
        case (kind)
            0: begin
                w = 14'h3100 | r[6:0];
                m_p[n] = (a + k) & 65535;
            end
            1, 2: begin
                w = (kind == 1 ? 14'h3900 : 14'h3e00) | v;
                arith(v, kind == 2, m_acc);
            end
            3, 4, 5, 6: begin
                if (kind < 5) begin
                    w = 14'h0010 | (kind == 3 ? 14'h0008 : 14'h0) | n << 2 | r[1:0];
                    m_p[n] = b;
                end else begin
                    w = 14'h3f00 | (kind == 5 ? 14'h0080 : 14'h0) | r[6:0];
                end
                e_stall = a[15] + (kind % 2 == 0 ? 1 : 0);
                if (kind % 2) begin
                    mem[x] = m_acc;
                end else begin
                    m_acc = mem[x];
                    m_z = m_acc == 0;
                end
            end
            default: begin
                w = (kind == 7 ? 14'h0500 : 14'h0700) | r[15] << 7 | f;
                e_stall = 1;
                arith(mem[f], kind == 8, res);
                if (r[15]) begin
                    mem[f] = res;
                end else begin
                    m_acc = res;
                end
            end
        endcase
        run(w, r[18:16] == 0);
    endtask
    // =====================================================================
    // main sequence
    initial begin
        seed = 35864;
        rst = 1'b1;
        {m_acc, m_z, m_c, m_dc, m_p[0], m_p[1]} = 0;
        m_to = 1;
        m_pd = 1;
        foreach (mem[i]) mem[i] = -1;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        foreach (iw[i]) begin
            step(2);
            e_pulse = {iw[i] == 14'h0064, iw[i] == 14'h0063,
                       iw[i][13:3] == 11'h00c && iw[i] != 14'h0063 && iw[i] != 14'h0064, iw[i] == 14'h0008, 1'b0};
            if (e_pulse[4:3] != 0) begin
                m_to = 1;
                m_pd = e_pulse[4];
            end
            run(iw[i], 1'b0);
            if (e_pulse[2]) begin
                cmp(dir_sel, iw[i] & 7);
                cmp(dir_data, m_acc);
            end
        end
        repeat (500) step(($random(seed) & 32'h7fffffff) % 9);
        i_fetch.offer(14'h0001, 1'b0);
        i_fetch.release_bus();
        cmp(soft_reset_pulse, 1);
        close_out();
    end
    initial begin
        #(20 * 20000);
        n_mismatch++;
        close_out();
    end
endmodule // iiad_core_bench
bind iiad_core iiad_core_properties i_props (.sys_clk, .rst, .instr_valid, .instr, .pc_change, .instr_ready, .acc,
    .pointer0, .carry_bit, .expiry_bit, .sleep_entry_bit, .watchdog_clear_pulse, .sleep_pulse, .dir_load_pulse,
    .dir_sel, .dir_data);
